// [core/dpsel_pkg.sv]
// package for the debug port bank and target select block
// assumes nothing beyond a synthesis tool that accepts packed structs
package dpsel_pkg;

  // ----------------------------------------------------------------
  // port register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] DPSEL_OFF_ID = 4'h0;
  localparam logic [3:0] DPSEL_OFF_BANKED = 4'h4;
  localparam logic [3:0] DPSEL_OFF_BANK_POINTER = 4'h8;
  localparam logic [3:0] DPSEL_OFF_TARGET_CHOICE = 4'hc;

  // ----------------------------------------------------------------
  // bank field values
  // ----------------------------------------------------------------
  localparam logic [3:0] DPSEL_BANK_IDENT = 4'h0;
  localparam logic [3:0] DPSEL_BANK_IDENT_ONE = 4'h1;
  localparam logic [3:0] DPSEL_BANK_BASE = 4'h2;
  localparam logic [3:0] DPSEL_BANK_ADDR_HIGH = 4'h5;
  localparam logic [3:0] DPSEL_BANK_RESET = 4'h0;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int DPSEL_BANK_LSB = 0;
  localparam int DPSEL_BANK_MSB = 3;
  localparam int DPSEL_ADDR_LOW_LSB = 4;
  localparam int DPSEL_REV_LSB = 28;
  localparam int DPSEL_PART_LSB = 12;
  localparam int DPSEL_DESIGNER_LSB = 1;
  localparam int DPSEL_CONT_LSB = 8;
  localparam logic [31:0] DPSEL_WORD_RESET = 32'h0000_0000;
  localparam logic [31:0] DPSEL_RES0 = 32'h0000_0000;
  localparam logic [1:0] DPSEL_BYTE_BITS = 2'h0;

  // ----------------------------------------------------------------
  // link-side request carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic ap;
    logic write;
    logic [3:0] offset;
    logic [31:0] wdata;
  } dpsel_req_t;

  // ----------------------------------------------------------------
  // state carried to the system clock
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] addr_high;
    logic [27:0] addr_low;
    logic [1:0] word;
    logic [3:0] bank;
    logic selected;
  } dpsel_view_t;

endpackage

// [core/dpsel_top.sv]
// debug port bank select, address select and multi-drop target select
// assumes a link protocol engine on link_clock delivering decoded port
// requests and a line reset pulse; the system side runs on clock
`timescale 1ns/10ps
`default_nettype none

// Operation
// - two write-only 32-bit address select registers
// - address 63:4 is high word over low 31:4
// - word bits from transaction, bits 1:0 zero
// - bank field picks registers at 0x0, 0x4
// - unlisted bank reads zero at 0x0, 0x4
// - power-up reset clears bank field
// - line reset clears bank field
// - low at 0x8 always, high at 0x4 bank 5
// - target identity readable at 0x4 bank 2
// - identity holds revision and part number
// - identity holds part designer code
// - designer code: continuation count, final byte low bits
// - identity bit 0 reads one
// - post line reset write selects on instance and identity match
// - mismatching selection write deselects device
// - data line undriven in selection write acknowledge
// - selection register write-only at 0xC, any bank
// - selection register present for protocol version 2
// - registers live in the always-on domain
module dpsel_top #(
  parameter logic [3:0] TARGET_REVISION = 4'h1,
  parameter logic [15:0] PART_NUMBER = 16'h1234,
  // designer code values are arbitrary
  parameter logic [3:0] DESIGNER_CONT = 4'h0,
  parameter logic [6:0] DESIGNER_CODE = 7'h11,
  parameter logic [3:0] INSTANCE_NUMBER = 4'h0,
  parameter logic [31:0] PORT_ID_VALUE = 32'h0000_0001,
  parameter logic [31:0] PORT_ID_ONE_VALUE = 32'h0000_0000,
  parameter logic [31:0] BASE_POINTER_VALUE = 32'h0000_0000
) (
  // system clock and power-up reset
  input wire logic clock,
  input wire logic reset,
  // link clock and link requests
  input wire logic link_clock,
  input wire dpsel_pkg::dpsel_req_t link_req,
  input wire logic link_line_reset,
  input wire logic [31:0] link_ctrl_stat_rdata,
  input wire logic [31:0] link_control_rdata,
  // link answers
  output logic [31:0] link_rdata_r,
  output logic link_rdata_valid_r,
  output logic link_line_oe_r,
  output logic link_selected_r,
  // system-side view
  output logic [63:0] ap_address_r,
  output logic [3:0] port_bank_field_r,
  output logic target_selected_r
);

  // ----------------------------------------------------------------
  // identity value
  // ----------------------------------------------------------------
  localparam logic [31:0] TARGET_ID = {TARGET_REVISION, PART_NUMBER, DESIGNER_CONT, DESIGNER_CODE, 1'b1};

  // ----------------------------------------------------------------
  // reset brought onto the link clock
  // ----------------------------------------------------------------
  logic link_rst_meta_r;
  logic link_rst_r;

  always_ff @(posedge link_clock) begin
    link_rst_meta_r <= reset;
    link_rst_r <= link_rst_meta_r;
  end

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  logic [31:0] addr_high_r;
  logic [31:0] addr_high_nxt;
  logic [31:0] bank_ptr_r;
  logic [31:0] bank_ptr_nxt;
  logic [1:0] word_r;
  logic armed_r;
  logic upd_toggle_r;
  logic dp_write;
  logic dp_read;
  logic wr_low;
  logic wr_high;
  logic wr_choice;
  logic choice_match;
  logic [3:0] bank;

  localparam int DPSEL_BANK_MSB_I = dpsel_pkg::DPSEL_BANK_MSB;
  localparam int DPSEL_BANK_LSB_I = dpsel_pkg::DPSEL_BANK_LSB;
  assign bank = bank_ptr_r[DPSEL_BANK_MSB_I:DPSEL_BANK_LSB_I];

  assign dp_write = link_req.valid && !link_req.ap && link_req.write;
  assign dp_read = link_req.valid && !link_req.ap && !link_req.write;
  assign wr_low = dp_write && (link_req.offset == dpsel_pkg::DPSEL_OFF_BANK_POINTER);
  assign wr_high = dp_write && (link_req.offset == dpsel_pkg::DPSEL_OFF_BANKED)
    && (bank == dpsel_pkg::DPSEL_BANK_ADDR_HIGH);
  assign wr_choice = dp_write && (link_req.offset == dpsel_pkg::DPSEL_OFF_TARGET_CHOICE);
  assign choice_match = (link_req.wdata[31:28] == INSTANCE_NUMBER)
    && (link_req.wdata[27:0] == TARGET_ID[27:0]);

  // ----------------------------------------------------------------
  // address select registers
  // ----------------------------------------------------------------
  always_comb begin
    addr_high_nxt = addr_high_r;
    if (wr_high) begin
      addr_high_nxt = link_req.wdata;
    end
  end

  always_comb begin
    bank_ptr_nxt = bank_ptr_r;
    if (link_line_reset) begin
      bank_ptr_nxt[DPSEL_BANK_MSB_I:DPSEL_BANK_LSB_I] = dpsel_pkg::DPSEL_BANK_RESET;
    end else if (wr_low) begin
      bank_ptr_nxt = link_req.wdata;
    end
  end

  always_ff @(posedge link_clock) begin
    if (link_rst_r) begin
      addr_high_r <= dpsel_pkg::DPSEL_WORD_RESET;
      bank_ptr_r <= dpsel_pkg::DPSEL_WORD_RESET;
    end else begin
      addr_high_r <= addr_high_nxt;
      bank_ptr_r <= bank_ptr_nxt;
    end
  end

  // word within the bank comes with each access port transaction
  always_ff @(posedge link_clock) begin
    if (link_rst_r) begin
      word_r <= 2'h0;
    end else if (link_req.valid && link_req.ap) begin
      word_r <= link_req.offset[3:2];
    end
  end

  // ----------------------------------------------------------------
  // multi-drop selection
  // ----------------------------------------------------------------
  always_ff @(posedge link_clock) begin
    if (link_rst_r) begin
      armed_r <= 1'b0;
    end else if (link_line_reset) begin
      armed_r <= 1'b1;
    end else if (link_req.valid) begin
      armed_r <= 1'b0;
    end
  end

  always_ff @(posedge link_clock) begin
    if (link_rst_r) begin
      link_selected_r <= 1'b1;
    end else if (wr_choice) begin
      link_selected_r <= armed_r && choice_match;
    end
  end

  // ----------------------------------------------------------------
  // read data and line drive
  // ----------------------------------------------------------------
  logic [31:0] rd_word;

  always_comb begin
    rd_word = dpsel_pkg::DPSEL_RES0;
    if (link_req.offset == dpsel_pkg::DPSEL_OFF_ID) begin
      case (bank)
        dpsel_pkg::DPSEL_BANK_IDENT: rd_word = PORT_ID_VALUE;
        dpsel_pkg::DPSEL_BANK_IDENT_ONE: rd_word = PORT_ID_ONE_VALUE;
        dpsel_pkg::DPSEL_BANK_BASE: rd_word = BASE_POINTER_VALUE;
        default: rd_word = dpsel_pkg::DPSEL_RES0;
      endcase
    end else if (link_req.offset == dpsel_pkg::DPSEL_OFF_BANKED) begin
      case (bank)
        dpsel_pkg::DPSEL_BANK_IDENT: rd_word = link_ctrl_stat_rdata;
        dpsel_pkg::DPSEL_BANK_IDENT_ONE: rd_word = link_control_rdata;
        dpsel_pkg::DPSEL_BANK_BASE: rd_word = TARGET_ID;
        default: rd_word = dpsel_pkg::DPSEL_RES0;
      endcase
    end
  end

  always_ff @(posedge link_clock) begin
    if (link_rst_r) begin
      link_rdata_r <= dpsel_pkg::DPSEL_RES0;
      link_rdata_valid_r <= 1'b0;
    end else begin
      link_rdata_valid_r <= dp_read;
      if (dp_read) begin
        link_rdata_r <= rd_word;
      end
    end
  end

  always_ff @(posedge link_clock) begin
    if (link_rst_r) begin
      link_line_oe_r <= 1'b0;
    end else begin
      link_line_oe_r <= link_req.valid && !wr_choice && link_selected_r;
    end
  end

  // ----------------------------------------------------------------
  // crossing: toggle announces a held view to the system clock
  // ----------------------------------------------------------------
  dpsel_pkg::dpsel_view_t view_r;

  always_ff @(posedge link_clock) begin
    if (link_rst_r) begin
      view_r <= '{addr_high: dpsel_pkg::DPSEL_WORD_RESET, addr_low: 28'h000_0000, word: 2'h0,
        bank: dpsel_pkg::DPSEL_BANK_RESET, selected: 1'b1};
      upd_toggle_r <= 1'b0;
    end else begin
      view_r <= '{addr_high: addr_high_nxt, addr_low: bank_ptr_nxt[31:4],
        word: (link_req.valid && link_req.ap) ? link_req.offset[3:2] : word_r,
        bank: bank_ptr_nxt[3:0],
        selected: wr_choice ? (armed_r && choice_match) : link_selected_r};
      if (link_req.valid || link_line_reset) begin
        upd_toggle_r <= !upd_toggle_r;
      end
    end
  end

  logic tog_meta_r;
  logic tog_sync_r;
  logic tog_seen_r;
  logic tog_edge;

  always_ff @(posedge clock) begin
    if (reset) begin
      tog_meta_r <= 1'b0;
      tog_sync_r <= 1'b0;
      tog_seen_r <= 1'b0;
    end else begin
      tog_meta_r <= upd_toggle_r;
      tog_sync_r <= tog_meta_r;
      tog_seen_r <= tog_sync_r;
    end
  end

  assign tog_edge = tog_sync_r != tog_seen_r;

  // ----------------------------------------------------------------
  // system-side outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      ap_address_r <= 64'h0000_0000_0000_0000;
      port_bank_field_r <= dpsel_pkg::DPSEL_BANK_RESET;
      target_selected_r <= 1'b1;
    end else if (tog_edge) begin
      ap_address_r <= {view_r.addr_high, view_r.addr_low, view_r.word, dpsel_pkg::DPSEL_BYTE_BITS};
      port_bank_field_r <= view_r.bank;
      target_selected_r <= view_r.selected;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_choice_write;
    dp_write && (link_req.offset == dpsel_pkg::DPSEL_OFF_TARGET_CHOICE);
  endsequence

  sequence s_armed_match;
    armed_r && choice_match;
  endsequence

  sequence s_port_read;
    dp_read && !link_line_reset;
  endsequence

  sequence s_ap_transaction;
    link_req.valid && link_req.ap;
  endsequence

  sequence s_line_reset_arms;
    link_line_reset ##1 armed_r;
  endsequence

  AST_LINE_RESET_BANK: assert property (@(posedge link_clock) disable iff (link_rst_r)
    link_line_reset |=> (bank == dpsel_pkg::DPSEL_BANK_RESET))
    else $error("bank field not cleared by line reset");

  AST_HIGH_WRITE: assert property (@(posedge link_clock) disable iff (link_rst_r)
    (dp_write && link_req.offset == dpsel_pkg::DPSEL_OFF_BANKED && bank == dpsel_pkg::DPSEL_BANK_ADDR_HIGH)
    |=> (addr_high_r == $past(link_req.wdata)))
    else $error("high select word not written");

  AST_LOW_WRITE: assert property (@(posedge link_clock) disable iff (link_rst_r)
    (wr_low && !link_line_reset) |=> (bank_ptr_r == $past(link_req.wdata)))
    else $error("low select word not written");

  AST_ID_READ: assert property (@(posedge link_clock) disable iff (link_rst_r)
    (dp_read && link_req.offset == dpsel_pkg::DPSEL_OFF_BANKED && bank == dpsel_pkg::DPSEL_BANK_BASE)
    |=> link_rdata_valid_r && (link_rdata_r == TARGET_ID) && link_rdata_r[0])
    else $error("identity read wrong");

  AST_RESERVED_ZERO: assert property (@(posedge link_clock) disable iff (link_rst_r)
    (dp_read && link_req.offset[3] == 1'b0 && bank > dpsel_pkg::DPSEL_BANK_BASE)
    |=> (link_rdata_r == dpsel_pkg::DPSEL_RES0))
    else $error("reserved bank read not zero");

  AST_CHOICE_UNDRIVEN: assert property (@(posedge link_clock) disable iff (link_rst_r)
    s_choice_write |=> !link_line_oe_r)
    else $error("line driven during selection acknowledge");

  AST_SELECT_MATCH: assert property (@(posedge link_clock) disable iff (link_rst_r)
    (s_choice_write ##0 s_armed_match) |=> link_selected_r ##1 (link_selected_r || $past(wr_choice)))
    else $error("matching selection ignored");

  AST_DESELECT: assert property (@(posedge link_clock) disable iff (link_rst_r)
    (s_choice_write ##0 !choice_match) |=> !link_selected_r)
    else $error("mismatching selection did not deselect");

  AST_VIEW_UPDATE: assert property (@(posedge clock) disable iff (reset)
    $changed(ap_address_r) |-> $past(tog_edge) && (ap_address_r[1:0] == dpsel_pkg::DPSEL_BYTE_BITS))
    else $error("address output changed without update");

  AST_POWERUP_BANK: assert property (@(posedge link_clock)
    link_rst_r |=> (bank == dpsel_pkg::DPSEL_BANK_RESET))
    else $error("bank field not cleared by power-up reset");

  AST_POWERUP_SYS_BANK: assert property (@(posedge clock)
    reset |=> (port_bank_field_r == dpsel_pkg::DPSEL_BANK_RESET) && target_selected_r)
    else $error("system copy not reset");

  AST_READ_NO_EFFECT: assert property (@(posedge link_clock) disable iff (link_rst_r)
    s_port_read |=> $stable(bank_ptr_r) && $stable(addr_high_r))
    else $error("read changed a select register");

  AST_HIGH_REFUSED: assert property (@(posedge link_clock) disable iff (link_rst_r)
    (dp_write && link_req.offset == dpsel_pkg::DPSEL_OFF_BANKED && bank != dpsel_pkg::DPSEL_BANK_ADDR_HIGH)
    |=> $stable(addr_high_r))
    else $error("high select word written outside its bank");

  AST_WORD_FROM_AP: assert property (@(posedge link_clock) disable iff (link_rst_r)
    s_ap_transaction |=> (word_r == $past(link_req.offset[3:2])))
    else $error("word not taken from access port transaction");

  AST_WORD_KEPT: assert property (@(posedge link_clock) disable iff (link_rst_r)
    (link_req.valid && !link_req.ap) |=> $stable(word_r))
    else $error("word changed by port register access");

  AST_BANK_ZERO_READ: assert property (@(posedge link_clock) disable iff (link_rst_r)
    (dp_read && link_req.offset == dpsel_pkg::DPSEL_OFF_ID && bank == dpsel_pkg::DPSEL_BANK_IDENT)
    |=> (link_rdata_r == PORT_ID_VALUE))
    else $error("bank 0 offset 0 read wrong");

  AST_BANK_ONE_READ: assert property (@(posedge link_clock) disable iff (link_rst_r)
    (dp_read && link_req.offset == dpsel_pkg::DPSEL_OFF_BANKED && bank == dpsel_pkg::DPSEL_BANK_IDENT_ONE)
    |=> (link_rdata_r == $past(link_control_rdata)))
    else $error("bank 1 offset 4 read wrong");

  AST_READ_ANSWER: assert property (@(posedge link_clock) disable iff (link_rst_r)
    dp_read |=> link_rdata_valid_r)
    else $error("read not answered");

  AST_CHOICE_KEEPS_SELECT: assert property (@(posedge link_clock) disable iff (link_rst_r)
    (s_choice_write ##0 !link_line_reset) |=> $stable(bank_ptr_r) && $stable(addr_high_r))
    else $error("selection write touched a select register");

  AST_LINE_RESET_ARMS: assert property (@(posedge link_clock) disable iff (link_rst_r)
    link_line_reset |-> s_line_reset_arms)
    else $error("line reset did not arm selection");

  AST_ARM_SPENT: assert property (@(posedge link_clock) disable iff (link_rst_r)
    (link_req.valid && !link_line_reset) |=> !armed_r)
    else $error("selection still armed after a request");

  AST_ADDR_COMPOSE: assert property (@(posedge clock) disable iff (reset)
    tog_edge |=> (ap_address_r[63:2] == {$past(view_r.addr_high), $past(view_r.addr_low), $past(view_r.word)}))
    else $error("address output not composed from select words");

  AST_SELECT_FOLLOWS: assert property (@(posedge clock) disable iff (reset)
    tog_edge |=> (target_selected_r == $past(view_r.selected)))
    else $error("system selection copy wrong");

endmodule

`default_nettype wire

// [bench/dpsel_probe.sv]
// probe model: issues decoded port requests and line resets on the link
// assumes the port block samples requests on the rising link_clock edge
`timescale 1ns/10ps
`default_nettype none
module dpsel_probe (
  // link clock
  input wire logic link_clock,
  // requests
  output var dpsel_pkg::dpsel_req_t req,
  output var logic line_reset,
  // answers
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic oe
);
  logic oe_seen;

  initial begin
    req = '0;
    line_reset = 1'b0;
    oe_seen = 1'b0;
  end

  // ----------------------------------------------------------------
  // request held to its taking edge, then released with inverted data
  // ----------------------------------------------------------------
  task automatic send(input logic ap, input logic wr, input logic [3:0] off, input logic [31:0] d);
    @(posedge link_clock);
    req <= '{1'b1, ap, wr, off, d};
    @(posedge link_clock);
    req <= '{1'b0, ap, wr, off, ~d};
    oe_seen = 1'b0;
  endtask

  // serial link only, so the selection offset is fair to use
  task automatic wr(input logic ap, input logic [3:0] off, input logic [31:0] d);
    send(ap, 1'b1, off, d);
    repeat (5) begin
      #1;
      if (oe === 1'b1) oe_seen = 1'b1;
      @(posedge link_clock);
    end
  endtask

  task automatic rd(input logic [3:0] off, output logic [31:0] d, output logic ok);
    send(1'b0, 1'b0, off, 32'h0000_0000);
    ok = 1'b0;
    d = 32'h0000_0000;
    repeat (3) begin
      #1;
      if (!ok && rvalid === 1'b1) begin
        ok = 1'b1;
        d = rdata;
      end
      @(posedge link_clock);
    end
  endtask

  task automatic lreset;
    @(posedge link_clock);
    line_reset <= 1'b1;
    @(posedge link_clock);
    line_reset <= 1'b0;
    repeat (3) @(posedge link_clock);
  endtask
endmodule
`default_nettype wire

// [bench/debug_port_bank_target_select_tb.sv]
// bench for the port bank, address and target select block
// assumes the probe model in dpsel_probe.sv and the package dpsel_pkg
`timescale 1ns/10ps
`default_nettype none
module debug_port_bank_target_select_tb;
  localparam logic [31:0] ID = 32'h35a6_b22b;
  localparam logic [31:0] SEL = 32'h65a6_b22b;
  localparam logic [31:0] PID = 32'h0bad_0001;
  localparam logic [31:0] PID1 = 32'h0000_0020;
  localparam logic [31:0] BASE = 32'h0000_4000;
  localparam logic [31:0] CS = 32'hc5c5_0000;
  localparam logic [31:0] DL = 32'h0000_0a0a;
  typedef struct packed {logic lr; logic [31:0] v; logic e;} dpsel_case_t;

  logic clock = 1'b0;
  logic link_clock = 1'b0;
  logic reset = 1'b1;
  dpsel_pkg::dpsel_req_t req;
  logic line_reset, rvalid, oe, lsel, tsel, ok;
  logic [31:0] rdata, d;
  logic [63:0] addr;
  logic [3:0] bank;
  int fails = 0;
  int num_checks = 0;
  int banks[6] = '{0, 1, 2, 3, 5, 15};
  dpsel_case_t cases[8] = '{'{1'b1, SEL, 1'b1}, '{1'b1, SEL ^ 32'h1000_0000, 1'b0}, '{1'b1, SEL, 1'b1},
    '{1'b0, SEL, 1'b0}, '{1'b1, 32'hffff_ffff, 1'b0}, '{1'b1, SEL & 32'hffff_fffe, 1'b0},
    '{1'b1, SEL ^ 32'h0000_1002, 1'b0}, '{1'b1, SEL, 1'b1}};

  always #50 clock = ~clock;
  initial begin
    #37;
    forever #80 link_clock = ~link_clock;
  end

  dpsel_top #(.TARGET_REVISION(4'h3), .PART_NUMBER(16'h5a6b), .DESIGNER_CONT(4'h2),
    .DESIGNER_CODE(7'h15), .INSTANCE_NUMBER(4'h6), .PORT_ID_VALUE(PID),
    .PORT_ID_ONE_VALUE(PID1), .BASE_POINTER_VALUE(BASE)) uut (
    .clock(clock), .reset(reset), .link_clock(link_clock), .link_req(req),
    .link_line_reset(line_reset), .link_ctrl_stat_rdata(CS), .link_control_rdata(DL),
    .link_rdata_r(rdata), .link_rdata_valid_r(rvalid), .link_line_oe_r(oe),
    .link_selected_r(lsel), .ap_address_r(addr), .port_bank_field_r(bank), .target_selected_r(tsel));

  dpsel_probe probe (.link_clock(link_clock), .req(req), .line_reset(line_reset),
    .rdata(rdata), .rvalid(rvalid), .oe(oe));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic sync;
    repeat (12) @(posedge clock);
  endtask

  task automatic do_reset;
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    repeat (4) @(posedge link_clock);
  endtask

  function automatic logic [31:0] exp_rd(input logic [3:0] b, input logic [3:0] off);
    if (off == 4'h0 && b == 4'h0) return PID;
    if (off == 4'h0 && b == 4'h1) return PID1;
    if (off == 4'h0 && b == 4'h2) return BASE;
    if (off == 4'h4 && b == 4'h0) return CS;
    if (off == 4'h4 && b == 4'h1) return DL;
    if (off == 4'h4 && b == 4'h2) return ID;
    return 32'h0000_0000;
  endfunction

  task automatic final_report;
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #1_000_000;
    fails++;
    final_report();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    chk(bank, 4'h0);
    chk(tsel, 1'b1);
    chk(addr, 64'h0);
    for (int i = 0; i < 6; i++) begin
      probe.wr(1'b0, 4'h8, {28'h0abc_def, banks[i][3:0]});
      sync();
      chk(bank, banks[i][3:0]);
      chk(probe.oe_seen, 1'b1);
      for (int o = 0; o < 16; o += 4) begin
        probe.rd(o[3:0], d, ok);
        chk(ok, 1'b1);
        chk(d, exp_rd(banks[i][3:0], o[3:0]));
      end
    end
    probe.wr(1'b0, 4'h8, 32'habcd_1235);
    probe.wr(1'b0, 4'h4, 32'h1357_9bdf);
    probe.wr(1'b0, 4'h8, 32'h2468_ace2);
    probe.wr(1'b0, 4'h4, 32'hffff_0000);
    for (int w = 0; w < 4; w++) begin
      probe.wr(1'b1, {w[1:0], 2'b00}, 32'h0000_0000);
      sync();
      chk(addr, {32'h1357_9bdf, 28'h2468_ace, w[1:0], 2'b00});
    end
    probe.lreset();
    sync();
    chk(bank, 4'h0);
    chk(addr, {32'h1357_9bdf, 28'h2468_ace, 2'b11, 2'b00});
    for (int i = 0; i < 8; i++) begin
      if (cases[i].lr) probe.lreset();
      probe.wr(1'b0, 4'hc, cases[i].v);
      sync();
      chk(lsel, cases[i].e);
      chk(tsel, cases[i].e);
      chk(probe.oe_seen, 1'b0);
    end
    probe.wr(1'b0, 4'hc, 32'hffff_ffff);
    probe.wr(1'b0, 4'h8, 32'h0000_0002);
    sync();
    chk(lsel, 1'b0);
    chk(bank, 4'h2);
    do_reset();
    sync();
    chk(bank, 4'h0);
    chk(addr, 64'h0);
    chk(tsel, 1'b1);
    chk(lsel, 1'b1);
    final_report();
  end
endmodule
`default_nettype wire
